// ### src/mbios_scanner.sv
`timescale 1ns/10ps
// Function
// - only function codes 3, 16, 23 issued
// - table holds up to 32 entries
// - per entry: read 0-125, write 0-100
// - totals: read 500, write 500, both 512
// - rate step 10 to 200 ms, 10 ms
// - period rounded up to step multiple
// - query sent when period timer expires
// - health table of two 16-bit words
// - entry n maps word (n-1)/16, bit (n-1)%16
// - disable range stops scanning its entries
// - disabled entry: close connection, health zero
// - health kept current, readable any time
// - deadline 1 ms to 50 s marks invalid
// - error: inputs zeroed or held per entry
module mbios_scanner
  import mbios_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MBIOS_MS_CYCLES      // clocks per ms
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         cfg_we,         // table write strobe
  input  wire logic [4:0]   cfg_idx,        // zero-based entry to write
  input  wire mbios_entry_t cfg_entry,      // entry contents
  input  wire logic [4:0]   step_units,     // rate step in 10 ms units
  input  wire logic         dis_en,         // disable-range control
  input  wire logic [5:0]   dis_lo,         // first disabled entry, one-based
  input  wire logic [5:0]   dis_hi,         // last disabled entry, one-based
  input  wire logic         req_ready,      // transport takes the query
  input  wire logic         rsp_valid,      // response arrived
  input  wire logic [4:0]   rsp_idx,        // entry of the response
  input  wire logic         rsp_ok,         // response valid, not an error
  output logic              req_valid_q,    // query pending
  output mbios_req_t        req_q,          // query contents
  output logic [1:0][15:0]  health_q,       // health words
  output logic [31:0]       close_mask_q,   // connections to close, pulse
  output logic [31:0]       invalid_mask_q, // entries gone invalid, pulse
  output logic [31:0]       zero_mask_q,    // inputs to zero, pulse
  output logic              cfg_ack_q,      // write accepted, pulse
  output logic              cfg_err_q       // write refused, pulse
);

  // ========================================================================
  // storage
  mbios_entry_t tbl_q [MBIOS_ENTRIES];      // scan table
  logic [15:0]  rem_q [MBIOS_ENTRIES];      // period time left, ms
  logic [15:0]  dl_q  [MBIOS_ENTRIES];      // deadline time left, ms
  logic [31:0]  pend_q;                     // query due per entry
  logic [31:0]  act_q;                      // previous active set
  logic [31:0]  act_d;                      // entries currently scanned
  logic [31:0]  issue_mask;                 // entry issued this cycle
  logic [4:0]   pick_idx;                   // lowest due entry
  logic [10:0]  sum_rd_q;                   // total read words
  logic [10:0]  sum_wr_q;                   // total written words
  logic [10:0]  new_rd;                     // total read after write
  logic [10:0]  new_wr;                     // total written after write
  logic         cfg_ok;                     // write passes the limits
  mbios_entry_t cfg_clamped;                // entry with ranges applied
  logic [7:0]   step_ms_q;                  // step length in ms
  logic [4:0]   step_clamp;                 // step in range
  logic         ms_tick;                    // ms pulse
  logic         step_tick;                  // step pulse

  // ========================================================================
  // tick generation
  mbios_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .clk         (clk),
    .rst_n       (rst_n),
    .step_ms     (step_ms_q),
    .ms_tick_q   (ms_tick),
    .step_tick_q (step_tick)
  );

  // ========================================================================
  // rate step, clamped and scaled to ms
  always_comb begin
    step_clamp = step_units;
    if (step_units < MBIOS_STEP_MIN) step_clamp = MBIOS_STEP_MIN;
    if (step_units > MBIOS_STEP_MAX) step_clamp = MBIOS_STEP_MAX;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) step_ms_q <= MBIOS_STEP_RST;
    else        step_ms_q <= 8'({3'h0, step_clamp} * MBIOS_STEP_UNIT_MS);
  end

  // ========================================================================
  // write check against word limits
  always_comb begin
    new_rd = sum_rd_q - 11'(tbl_q[cfg_idx].rd_len) + 11'(cfg_entry.rd_len);
    new_wr = sum_wr_q - 11'(tbl_q[cfg_idx].wr_len) + 11'(cfg_entry.wr_len);
    cfg_ok = (cfg_entry.rd_len <= MBIOS_RD_MAX) && (cfg_entry.wr_len <= MBIOS_WR_MAX)
          && (new_rd <= MBIOS_TOT_RD_MAX) && (new_wr <= MBIOS_TOT_WR_MAX)
          && (new_rd + new_wr <= MBIOS_TOT_ALL_MAX);
    cfg_clamped = cfg_entry;
    cfg_clamped.entry_period = mbios_clamp16(cfg_entry.entry_period,
                                             MBIOS_PERIOD_MIN, MBIOS_PERIOD_MAX);
    cfg_clamped.response_deadline = mbios_clamp16(cfg_entry.response_deadline,
                                    MBIOS_DEADLINE_MIN, MBIOS_DEADLINE_MAX);
  end

  // ========================================================================
  // scan table and totals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MBIOS_ENTRIES; i++) tbl_q[i] <= '0;
      sum_rd_q  <= 11'h000;
      sum_wr_q  <= 11'h000;
      cfg_ack_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end else begin
      cfg_ack_q <= cfg_we && cfg_ok;
      cfg_err_q <= cfg_we && !cfg_ok;
      // refused writes leave the table untouched
      if (cfg_we && cfg_ok) begin
        tbl_q[cfg_idx] <= cfg_clamped;
        sum_rd_q       <= new_rd;
        sum_wr_q       <= new_wr;
      end
    end
  end

  // ========================================================================
  // active set: enabled and outside the disable range
  always_comb begin
    for (int i = 0; i < MBIOS_ENTRIES; i++) begin
      act_d[i] = tbl_q[i].enable && !(dis_en && mbios_in_range(5'(i), dis_lo, dis_hi));
    end
  end

  // ========================================================================
  // period timers, expiry at step boundaries gives round-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MBIOS_ENTRIES; i++) rem_q[i] <= 16'h0000;
      pend_q <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < MBIOS_ENTRIES; i++) begin
        if (cfg_we && cfg_ok && cfg_idx == 5'(i)) begin
          // fresh entry restarts its period
          rem_q[i]  <= cfg_clamped.entry_period;
          pend_q[i] <= 1'b0;
        end else if (!act_d[i]) begin
          // idle entries sit reloaded with nothing due
          rem_q[i]  <= tbl_q[i].entry_period;
          pend_q[i] <= 1'b0;
        end else if (step_tick && rem_q[i] <= 16'(step_ms_q)) begin
          // expiry: partial step counts as a whole one
          rem_q[i]  <= tbl_q[i].entry_period;
          pend_q[i] <= mbios_fc(tbl_q[i].rd_len, tbl_q[i].wr_len) != MBIOS_FC_NONE;
        end else begin
          if (step_tick) rem_q[i] <= rem_q[i] - 16'(step_ms_q);
          // issue clears, a same-cycle expiry above wins
          if (issue_mask[i]) pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // pick lowest due entry while the query slot is free
  always_comb begin
    issue_mask = 32'h0000_0000;
    pick_idx   = 5'h00;
    for (int i = MBIOS_ENTRIES - 1; i >= 0; i--) begin
      if (pend_q[i]) pick_idx = 5'(i);
    end
    if (!req_valid_q && pend_q != 32'h0000_0000) issue_mask[pick_idx] = 1'b1;
  end

  // ========================================================================
  // query slot, held until the transport takes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_valid_q <= 1'b0;
      req_q       <= '0;
    end else if (issue_mask != 32'h0000_0000) begin
      req_valid_q   <= 1'b1;
      req_q.entry   <= pick_idx;
      req_q.func    <= mbios_fc(tbl_q[pick_idx].rd_len, tbl_q[pick_idx].wr_len);
      req_q.rd_len  <= tbl_q[pick_idx].rd_len;
      req_q.wr_len  <= tbl_q[pick_idx].wr_len;
    end else if (req_valid_q && req_ready) begin
      req_valid_q <= 1'b0;
    end
  end

  // ========================================================================
  // health, deadlines and error fallbacks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MBIOS_ENTRIES; i++) dl_q[i] <= 16'h0000;
      health_q       <= {MBIOS_HEALTH_RST, MBIOS_HEALTH_RST};
      invalid_mask_q <= 32'h0000_0000;
      zero_mask_q    <= 32'h0000_0000;
    end else begin
      invalid_mask_q <= 32'h0000_0000;
      zero_mask_q    <= 32'h0000_0000;
      for (int i = 0; i < MBIOS_ENTRIES; i++) begin
        if (!act_d[i]) begin
          // not scanned: unhealthy, deadline parked
          health_q[i / 16][i % 16] <= 1'b0;
          // a write in this cycle parks the new deadline, not the stale one
          if (cfg_we && cfg_ok && cfg_idx == 5'(i)) dl_q[i] <= cfg_clamped.response_deadline;
          else                                      dl_q[i] <= tbl_q[i].response_deadline;
        end else if (rsp_valid && rsp_idx == 5'(i) && rsp_ok) begin
          // good answer wins over a deadline ending now
          health_q[i / 16][i % 16] <= 1'b1;
          dl_q[i] <= tbl_q[i].response_deadline;
        end else if ((rsp_valid && rsp_idx == 5'(i))
                  || (ms_tick && dl_q[i] <= 16'h0001)) begin
          // error answer or deadline gone: inputs invalid
          health_q[i / 16][i % 16] <= 1'b0;
          invalid_mask_q[i]        <= 1'b1;
          zero_mask_q[i]           <= !tbl_q[i].hold_last;
          dl_q[i] <= tbl_q[i].response_deadline;
        end else if (ms_tick) begin
          dl_q[i] <= dl_q[i] - 16'h0001;
        end
      end
    end
  end

  // ========================================================================
  // connection close on leaving the active set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q        <= 32'h0000_0000;
      close_mask_q <= 32'h0000_0000;
    end else begin
      act_q        <= act_d;
      close_mask_q <= act_q & ~act_d;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_fc_legal: assert property (req_valid_q |-> (req_q.func == MBIOS_FC_READ
      || req_q.func == MBIOS_FC_WRITE || req_q.func == MBIOS_FC_RDWR))
    else $error("illegal function code issued");
  chk_entry_len_max: assert property (req_valid_q |->
      (req_q.rd_len <= MBIOS_RD_MAX && req_q.wr_len <= MBIOS_WR_MAX))
    else $error("entry length over limit");
  chk_word_totals: assert property (sum_rd_q <= MBIOS_TOT_RD_MAX
      && sum_wr_q <= MBIOS_TOT_WR_MAX && sum_rd_q + sum_wr_q <= MBIOS_TOT_ALL_MAX)
    else $error("word totals over limit");
  chk_step_range: assert property (##1 (step_ms_q >= 8'h0A && step_ms_q <= 8'hC8
      && step_ms_q % 8'h0A == 8'h00))
    else $error("rate step out of range");
  chk_period_range: assert property ((cfg_we && cfg_ok) |=>
      (tbl_q[$past(cfg_idx)].entry_period >= MBIOS_PERIOD_MIN
       && tbl_q[$past(cfg_idx)].entry_period <= MBIOS_PERIOD_MAX))
    else $error("period outside range");
  chk_req_hold: assert property ((req_valid_q && !req_ready) |=>
      (req_valid_q && $stable(req_q)))
    else $error("query dropped before taken");
  chk_disabled_idle: assert property ((pend_q & ~act_q) == 32'h0000_0000)
    else $error("query due on disabled entry");
  chk_close_unhealthy: assert property ((act_q & ~act_d) != 32'h0000_0000 |=>
      (close_mask_q == $past(act_q & ~act_d) && (health_q & close_mask_q) == 32'h0))
    else $error("disabled entry not closed or still healthy");
  chk_rsp_healthy: assert property ((rsp_valid && rsp_ok && act_d[rsp_idx]) |=>
      health_q[$past(rsp_idx) / 16][$past(rsp_idx) % 16])
    else $error("good response did not set health");
  chk_invalid_clear: assert property (invalid_mask_q != 32'h0 |->
      (health_q & invalid_mask_q) == 32'h0)
    else $error("invalid entry still healthy");

  cov_read_query: cover property (req_valid_q && req_ready && req_q.func == MBIOS_FC_READ);
  cov_rdwr_query: cover property (req_valid_q && req_ready && req_q.func == MBIOS_FC_RDWR);
  cov_close: cover property (close_mask_q != 32'h0);
  cov_timeout_zero: cover property (zero_mask_q != 32'h0);

endmodule : mbios_scanner

// ### inc/mbios_pkg.sv
// ==========================================================================
// scanner constants, carriers and helpers
package mbios_pkg;

  // ========================================================================
  // table geometry and function codes
  localparam int unsigned MBIOS_ENTRIES  = 32;           // scan table depth
  localparam logic [7:0]  MBIOS_FC_READ  = 8'h03;        // read registers
  localparam logic [7:0]  MBIOS_FC_WRITE = 8'h10;        // write registers
  localparam logic [7:0]  MBIOS_FC_RDWR  = 8'h17;        // read/write registers
  localparam logic [7:0]  MBIOS_FC_NONE  = 8'h00;        // idle entry

  // ========================================================================
  // word limits
  localparam logic [6:0]  MBIOS_RD_MAX      = 7'h7D;     // 125 words per entry
  localparam logic [6:0]  MBIOS_WR_MAX      = 7'h64;     // 100 words per entry
  localparam logic [10:0] MBIOS_TOT_RD_MAX  = 11'h1F4;   // 500 words read
  localparam logic [10:0] MBIOS_TOT_WR_MAX  = 11'h1F4;   // 500 words written
  localparam logic [10:0] MBIOS_TOT_ALL_MAX = 11'h200;   // 512 words together

  // ========================================================================
  // rate step and period ranges
  localparam logic [7:0]  MBIOS_STEP_UNIT_MS = 8'h0A;    // step granule, 10 ms
  localparam logic [4:0]  MBIOS_STEP_MIN     = 5'h01;    // 10 ms
  localparam logic [4:0]  MBIOS_STEP_MAX     = 5'h14;    // 200 ms
  localparam logic [15:0] MBIOS_PERIOD_MIN   = 16'h000A; // 10 ms
  localparam logic [15:0] MBIOS_PERIOD_MAX   = 16'hEA60; // 60000 ms
  localparam logic [15:0] MBIOS_DEADLINE_MIN = 16'h0001; // 1 ms
  localparam logic [15:0] MBIOS_DEADLINE_MAX = 16'hC350; // 50000 ms

  // ========================================================================
  // timing
  localparam int unsigned MBIOS_CLK_PERIOD_NS = 4;       // 250 MHz
  localparam int unsigned MBIOS_MS_NS         = 1000000; // one millisecond
  localparam int unsigned MBIOS_MS_CYCLES     = MBIOS_MS_NS / MBIOS_CLK_PERIOD_NS;

  // ========================================================================
  // reset values
  localparam logic [15:0] MBIOS_HEALTH_RST = 16'h0000;   // all unhealthy
  localparam logic [7:0]  MBIOS_STEP_RST   = 8'h0A;      // 10 ms step

  // ========================================================================
  // carriers
  typedef struct packed {
    logic        enable;       // entry listed for scanning
    logic        hold_last;    // 1: hold inputs on error, 0: fall back to zero
    logic [6:0]  rd_len;       // words to read
    logic [6:0]  wr_len;       // words to write
    logic [15:0] entry_period; // repetitive period in ms
    logic [15:0] response_deadline; // health timeout in ms
  } mbios_entry_t;

  typedef struct packed {
    logic [4:0]  entry;        // zero-based entry index
    logic [7:0]  func;         // function code
    logic [6:0]  rd_len;       // words to read
    logic [6:0]  wr_len;       // words to write
  } mbios_req_t;

  // ========================================================================
  // helpers
  // function code chosen from the lengths
  function automatic logic [7:0] mbios_fc(input logic [6:0] rd, input logic [6:0] wr);
    if (rd != 7'h00 && wr != 7'h00) return MBIOS_FC_RDWR;
    if (rd != 7'h00) return MBIOS_FC_READ;
    if (wr != 7'h00) return MBIOS_FC_WRITE;
    return MBIOS_FC_NONE;
  endfunction : mbios_fc

  // clamp a millisecond figure into a range
  function automatic logic [15:0] mbios_clamp16(input logic [15:0] v,
                                                input logic [15:0] lo,
                                                input logic [15:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : mbios_clamp16

  // zero-based index inside a one-based inclusive range
  function automatic logic mbios_in_range(input logic [4:0] idx,
                                          input logic [5:0] lo,
                                          input logic [5:0] hi);
    logic [5:0] n;
    n = {1'b0, idx} + 6'h01;
    return (n >= lo) && (n <= hi);
  endfunction : mbios_in_range

endpackage : mbios_pkg

// ### src/mbios_tick.sv
`timescale 1ns/10ps
// ==========================================================================
// millisecond and rate-step tick generator
module mbios_tick
  import mbios_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MBIOS_MS_CYCLES     // clocks per ms
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] step_ms,       // step length in ms
  output logic            ms_tick_q,     // one pulse per ms
  output logic            step_tick_q    // one pulse per step
);

  logic [17:0] cyc_q;                    // cycle counter within a ms
  logic [7:0]  ms_cnt_q;                 // ms counter within a step
  logic        ms_end;                   // last cycle of a ms

  assign ms_end = (cyc_q == 18'(MS_CYCLES - 1));

  // ========================================================================
  // millisecond divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q     <= 18'h00000;
      ms_tick_q <= 1'b0;
    end else begin
      cyc_q     <= ms_end ? 18'h00000 : cyc_q + 18'h00001;
      ms_tick_q <= ms_end;
    end
  end

  // ========================================================================
  // step divider, counts whole milliseconds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q    <= 8'h00;
      step_tick_q <= 1'b0;
    end else begin
      step_tick_q <= 1'b0;
      if (ms_tick_q) begin
        // >= copes with a step shortened on the fly
        if (ms_cnt_q + 8'h01 >= step_ms) begin
          ms_cnt_q    <= 8'h00;
          step_tick_q <= 1'b1;
        end else begin
          ms_cnt_q <= ms_cnt_q + 8'h01;
        end
      end
    end
  end

endmodule : mbios_tick

// ### tb/mbios_slave_model.sv
`timescale 1ns/10ps
// ==========================================================================
// remote slave: takes one query at a time, answers three cycles after the take
module mbios_slave_model
  import mbios_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        req_valid_q,
  input  wire mbios_req_t  req_q,
  input  wire logic [31:0] mute,             // entries that stay silent
  input  wire logic [31:0] bad,              // entries answered with an error
  output logic             req_ready = 1'b0,
  output logic             rsp_valid = 1'b0,
  output logic [4:0]       rsp_idx   = 5'h00,
  output logic             rsp_ok    = 1'b0
);
  logic [4:0] idx;                           // entry being served
  logic       slow = 1'b0;                   // alternates prompt and slow take
  // all changes land on the falling edge
  initial forever begin
    @(negedge clk);
    if (req_valid_q) begin
      repeat (slow ? 3 : 0) @(negedge clk);
      slow      = ~slow;
      idx       = req_q.entry;
      req_ready = 1'b1;
      @(negedge clk);
      req_ready = 1'b0;
      repeat (2) @(negedge clk);
      rsp_idx   = idx;
      rsp_ok    = ~bad[idx];
      rsp_valid = ~mute[idx];
      @(negedge clk);
      rsp_valid = 1'b0;
      rsp_idx   = ~idx;
    end
  end
endmodule : mbios_slave_model

// ### tb/tb_mbios_scanner.sv
`timescale 1ns/10ps
// ==========================================================================
// bench: word limits, traffic, disable range, failing slaves
module tb_mbios_scanner
  import mbios_pkg::*;
();
  logic             clk = 1'b0, rst_n = 1'b0, cfg_we = 1'b0, dis_en = 1'b0;
  logic [4:0]       cfg_idx = 5'h00, step_units = 5'h01;
  logic [5:0]       dis_lo = 6'h11, dis_hi = 6'h20;  // entries 17 to 32
  mbios_entry_t     cfg_entry = '0;
  logic [31:0]      mute = '0, bad = '0;
  logic             req_ready, rsp_valid, rsp_ok, req_valid_q, cfg_ack_q, cfg_err_q;
  logic [4:0]       rsp_idx, e;
  mbios_req_t       req_q;
  logic [1:0][15:0] health_q;
  logic [31:0]      close_mask_q, invalid_mask_q, zero_mask_q;
  logic [6:0]       rd_tab [32], wr_tab [32];          // accepted lengths
  logic [7:0]       fc_tab [32];                       // expected codes
  int               st_tab [32], last_t [32];          // period in 10 ms units, last query
  int               inv [2] = '{0, 0}, zr [2] = '{0, 0};
  int               errors = 0, samples_checked = 0, seed = 35;
  int               cyc = 0, closes = 0, dis_cyc = 0;
  logic [1:0]       exp_q [$];                         // 2'b10 accepted, 2'b01 refused

  always #2 clk = ~clk;

  mbios_scanner #(.MS_CYCLES(10)) u_mbios_scanner (
    .clk(clk), .rst_n(rst_n), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
    .cfg_entry(cfg_entry), .step_units(step_units), .dis_en(dis_en),
    .dis_lo(dis_lo), .dis_hi(dis_hi), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_idx(rsp_idx), .rsp_ok(rsp_ok),
    .req_valid_q(req_valid_q), .req_q(req_q), .health_q(health_q),
    .close_mask_q(close_mask_q), .invalid_mask_q(invalid_mask_q),
    .zero_mask_q(zero_mask_q), .cfg_ack_q(cfg_ack_q), .cfg_err_q(cfg_err_q));

  mbios_slave_model u_mbios_slave_model (
    .clk(clk), .req_valid_q(req_valid_q), .req_q(req_q), .mute(mute),
    .bad(bad), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_idx(rsp_idx), .rsp_ok(rsp_ok));

  // ========================================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // twelve-cycle reset, length and last-query tables emptied with it
  task automatic do_reset;
    rst_n  = 1'b0;
    rd_tab = '{default: 7'h00};
    wr_tab = '{default: 7'h00};
    last_t = '{default: 0};
    repeat (12) @(negedge clk);
    rst_n  = 1'b1;
  endtask : do_reset

  // table write, verdict reckoned from the word limits; caller drops cfg_we
  task automatic cfg(input logic [4:0] i, input logic [6:0] rd, wr,
                     input logic [15:0] per, input logic hold);
    int   sr, sw;
    logic ok;
    sr = rd;
    sw = wr;
    for (int k = 0; k < 32; k++) if (k != i) sr += rd_tab[k];
    for (int k = 0; k < 32; k++) if (k != i) sw += wr_tab[k];
    ok = rd <= 125 && wr <= 100 && sr <= 500 && sw <= 500 && sr + sw <= 512;
    if (ok) begin
      rd_tab[i] = rd;
      wr_tab[i] = wr;
      fc_tab[i] = rd == 0 ? MBIOS_FC_WRITE : wr == 0 ? MBIOS_FC_READ : MBIOS_FC_RDWR;
      st_tab[i] = (per + 10 * step_units - 1) / (10 * step_units) * step_units;
    end
    exp_q.push_back({ok, !ok});
    cfg_idx   = i;
    cfg_entry = '{1'b1, hold, rd, wr, per, 16'h0032};
    cfg_we    = 1'b1;
    @(negedge clk);
  endtask : cfg

  // ========================================================================
  // watcher: write verdicts, pulses, queries taken by the slave
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 5000) begin
      errors++;
      stop_test();
    end
    if (cfg_ack_q || cfg_err_q) check({cfg_ack_q, cfg_err_q}, exp_q.pop_front());
    if (close_mask_q[16]) closes++;
    for (int b = 0; b < 2; b++) if (invalid_mask_q[b]) inv[b]++;
    for (int b = 0; b < 2; b++) if (zero_mask_q[b]) zr[b]++;
    if (rst_n && req_valid_q && req_ready) begin
      e = req_q.entry;
      check(req_q.func, fc_tab[e]);
      check({req_q.rd_len, req_q.wr_len}, {rd_tab[e], wr_tab[e]});
      if (last_t[e] != 0) check((cyc - last_t[e] + 50) / 100, st_tab[e]);
      last_t[e] = cyc;
      if (dis_en && e >= 16 && cyc > dis_cyc + 20) check(e, 0);
    end
  end

  // ========================================================================
  // main sequence
  initial begin
    do_reset();
    check(health_q, 32'h0);
    cfg(5'h00, 7'h7E, 7'h00, 16'h0014, 1'b1);
    for (int k = 0; k < 4; k++) cfg(5'(k), 7'h7D, 7'h00, 16'h0014, 1'b1);
    cfg(5'h04, 7'h01, 7'h00, 16'h0014, 1'b1);
    cfg(5'h04, 7'h00, 7'h65, 16'h0014, 1'b1);
    cfg(5'h04, 7'h00, 7'h0C, 16'h0014, 1'b1);
    cfg(5'h05, 7'h00, 7'h01, 16'h0014, 1'b1);
    cfg_we = 1'b0;
    repeat (700) @(negedge clk);
    // second reset at a 20 ms step, random lengths; 25 ms rounds up to 40
    step_units = 5'h02;
    do_reset();
    cfg(5'h00, 7'(1 + ($random(seed) & 7)), 7'h00, 16'h0014, 1'b1);
    cfg(5'h01, 7'(1 + ($random(seed) & 7)), 7'(1 + ($random(seed) & 7)), 16'h0014, 1'b0);
    cfg(5'h10, 7'h00, 7'(1 + ($random(seed) & 7)), 16'h0019, 1'b1);
    cfg_we = 1'b0;
    repeat (1000) @(negedge clk);
    check(health_q[0][1:0], 2'b11);
    check(health_q[1][0], 1'b1);
    dis_en  = 1'b1;
    dis_cyc = cyc;
    repeat (10) @(negedge clk);
    check(closes, 1);
    check(health_q[1][0], 1'b0);
    bad[1]  = 1'b1;
    mute[0] = 1'b1;
    repeat (800) @(negedge clk);
    check(health_q[0][1:0], 2'b00);
    check(inv[1] > 0 && zr[1] == inv[1], 1);
    check(inv[0] > 0 && zr[0] == 0, 1);
    check(exp_q.size(), 0);
    stop_test();
  end
endmodule : tb_mbios_scanner
